// [fcg_pkg.sv]
// Purpose: constants, register map and types of the frequency counter input/gate block
// Assumes: 125 MHz system clock, synchronous pin inputs, 16-bit register port
// Notes:   all offsets are word addresses, one per 16-bit register, on the plain register port
`default_nettype none
package fcg_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
    localparam int REF_A_KHZ     = 1;
    localparam int REF_B_KHZ     = 100;
    localparam int REF_C_KHZ     = 900;
    localparam int GATE_A_MS     = 1;
    localparam int GATE_B_MS     = 4;
    localparam int GATE_C_MS     = 8;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 16;
    localparam int CNT_W         = 16;
    localparam int IRQ_W         = 3;

    localparam logic [7:0] ADDR_CHAN     = 8'h20;
    localparam logic [7:0] ADDR_PORT     = 8'h21;
    localparam logic [7:0] ADDR_MODE     = 8'h22;
    localparam logic [7:0] ADDR_CTRL     = 8'h23;
    localparam logic [7:0] ADDR_GSTAT    = 8'h24;
    localparam logic [7:0] ADDR_IRQ_ST   = 8'h25;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h26;
    localparam logic [7:0] ADDR_COUNT    = 8'h27;
    localparam logic [7:0] ADDR_PINS     = 8'h28;

    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int GSTAT_OPEN_BIT = 0;
    localparam int IRQ_IF_DONE    = 0;
    localparam int IRQ_EXT_DONE   = 1;
    localparam int IRQ_SAT        = 2;

    localparam logic [1:0] FUNC_EXT     = 2'h0;
    localparam logic [1:0] FUNC_AM      = 2'h1;
    localparam logic [1:0] FUNC_FM_HALF = 2'h2;
    localparam logic [1:0] FUNC_FM      = 2'h3;
    localparam logic [1:0] SEL_A        = 2'h0;
    localparam logic [1:0] SEL_B        = 2'h1;
    localparam logic [1:0] SEL_C        = 2'h2;
    localparam logic [1:0] SEL_OPEN     = 2'h3;
    localparam logic [1:0] CHAN_PIN_A   = 2'h1;
    localparam logic [1:0] CHAN_PIN_B   = 2'h2;

    localparam logic [3:0] MODE_RST  = 4'h0;
    localparam logic [1:0] CHAN_RST  = 2'h0;
    localparam logic [1:0] PORT_RST  = 2'h0;
    localparam logic [2:0] IRQ_RST   = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_IFON = 4'h2,
        ST_ARM  = 4'h4,
        ST_MEAS = 4'h8
    } fcg_state_t;
endpackage
`default_nettype wire

// [fcg_cnt_if.sv]
// Purpose: carries increment, clear and count between control and counter
// Assumes: one clock domain
// Notes:   inc and clr are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface fcg_cnt_if #(parameter int W = 16);
    logic         inc;
    logic         clr;
    logic [W-1:0] value;
    logic         satPulse;
    modport ctl (output inc, output clr, input value, input satPulse);
    modport cnt (input inc, input clr, output value, output satPulse);
endinterface
`default_nettype wire

// [fcg_timebase.sv]
// Purpose: three reference enables from the system clock by phase accumulation
// Assumes: ClkKhz is the clock rate in kHz
// Notes:   restart realigns every phase so a gate begins a full period later
`timescale 1ns/100ps
`default_nettype none
module fcg_timebase import fcg_pkg::*; #(
    parameter int ClkKhz = CLK_KHZ
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       restart,
    // enables: 0 slowest, 2 fastest
    output logic [2:0]      refTick
);
    localparam int RATES [3] = '{REF_A_KHZ, REF_B_KHZ, REF_C_KHZ};

    if (ClkKhz < 2 * REF_C_KHZ) begin : g_chk
        $error("fcg_timebase: clock too slow for fastest reference");
    end

    for (genvar i = 0; i < 3; i++) begin : g_acc
        logic [31:0] acc_ff;
        logic [31:0] sum;
        logic        wrap;
        assign sum  = acc_ff + 32'(RATES[i]);
        assign wrap = (sum >= 32'(ClkKhz));
        always_ff @(posedge clk) begin
            if (!rst_b || restart) begin
                acc_ff     <= 32'h0;
                refTick[i] <= 1'b0;
            end else begin
                acc_ff     <= wrap ? sum - 32'(ClkKhz) : sum;
                refTick[i] <= wrap;
            end
        end
    end
endmodule
`default_nettype wire

// [fcg_counter.sv]
// Purpose: saturating up counter shared by both counting functions
// Assumes: inc is a one-cycle pulse
// Notes:   clear wins over increment in the same cycle
`timescale 1ns/100ps
`default_nettype none
module fcg_counter import fcg_pkg::*; (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // control side
    fcg_cnt_if.cnt    cif
);
    localparam int W = $bits(cif.value);
    logic [W-1:0] cnt_ff;
    logic         sat_ff;
    wire          full = &cnt_ff;

    assign cif.value    = cnt_ff;
    assign cif.satPulse = sat_ff;

    always_ff @(posedge clk) begin
        if (!rst_b || cif.clr) begin
            cnt_ff <= '0;
            sat_ff <= 1'b0;
        end else begin
            sat_ff <= 1'b0;
            if (cif.inc && !full) begin
                cnt_ff <= cnt_ff + 1'b1;
                sat_ff <= (cnt_ff == {{(W-1){1'b1}}, 1'b0});
            end
        end
    end
endmodule
`default_nettype wire

// [fcg_top.sv]
// Purpose: input selection, gate timing and register port of the frequency counter
// Assumes: pins synchronous to clk; one strobe per cycle on the register port
// Notes:   count readable at its own address; three sticky events drive irq
`timescale 1ns/100ps
`default_nettype none
module fcg_top import fcg_pkg::*; #(
    parameter int ClkKhz = CLK_KHZ
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrEn,
    input  wire logic              rdEn,
    output logic [DATA_W-1:0]      rdData,
    // intermediate-frequency inputs
    input  wire logic              fmIfInputPin,
    input  wire logic              amIfInputPin,
    // gate pins, two-way
    input  wire logic              gateInputPinA_i,
    output logic                   gateInputPinA_o,
    output logic                   gateInputPinA_oe,
    input  wire logic              gateInputPinB_i,
    output logic                   gateInputPinB_o,
    output logic                   gateInputPinB_oe,
    // status
    output logic                   gateOpenFlag,
    output logic                   irq
);
    if (ClkKhz < 2 * REF_C_KHZ) begin : g_chk
        $error("fcg_top: ClkKhz too small");
    end

    fcg_cnt_if #(.W(CNT_W)) cif ();

    fcg_counter u_cnt (
        .clk   (clk),
        .rst_b (rst_b),
        .cif   (cif)
    );

    logic [2:0] refTick;
    logic       tbRestart;

    fcg_timebase #(.ClkKhz(ClkKhz)) u_tb (
        .clk     (clk),
        .rst_b   (rst_b),
        .restart (tbRestart),
        .refTick (refTick)
    );

    // registers
    logic [3:0]       mode_ff;
    logic [1:0]       chanSel_ff;
    logic [1:0]       portDir_ff;
    logic [1:0]       portOut_ff;
    logic [IRQ_W-1:0] irqSt_ff;
    logic [IRQ_W-1:0] irqMask_ff;
    logic [DATA_W-1:0] rdData_ff;
    fcg_state_t       state_ff;
    fcg_state_t       nxt_state;
    logic [3:0]       msCnt_ff;
    logic [3:0]       nxt_msCnt;
    logic             halfPhase_ff;
    logic             ifPinPrev_ff;
    logic             gatePrev_ff;

    // address decode
    wire wrChan  = wrEn && (addr == ADDR_CHAN);
    wire wrPort  = wrEn && (addr == ADDR_PORT);
    wire wrMode  = wrEn && (addr == ADDR_MODE);
    wire wrCtrl  = wrEn && (addr == ADDR_CTRL);
    wire wrIrqSt = wrEn && (addr == ADDR_IRQ_ST);
    wire wrMask  = wrEn && (addr == ADDR_IRQ_MASK);

    wire startCmd = wrCtrl && wrData[CTRL_START_BIT];
    wire clearCmd = wrCtrl && wrData[CTRL_CLEAR_BIT];

    // function and timing fields
    wire [1:0] funcSel = mode_ff[3:2];
    wire [1:0] timeSel = mode_ff[1:0];
    wire       isExt   = (funcSel == FUNC_EXT);
    wire       isHalf  = (funcSel == FUNC_FM_HALF);

    // IF input selection; the other pin is only read through the pin register
    wire ifPin  = (funcSel == FUNC_AM) ? amIfInputPin : fmIfInputPin;
    wire ifRise = ifPin && !ifPinPrev_ff;
    wire ifEdge = ifRise && (!isHalf || halfPhase_ff);

    // gate pin selection; a pin driven as output never gates
    wire gateA   = (chanSel_ff == CHAN_PIN_A) && !portDir_ff[0] && gateInputPinA_i;
    wire gateB   = (chanSel_ff == CHAN_PIN_B) && !portDir_ff[1] && gateInputPinB_i;
    wire gateLvl = gateA || gateB;
    wire gateRise = gateLvl && !gatePrev_ff;
    wire gateFall = !gateLvl && gatePrev_ff;

    // reference selection; code 11 yields no reference
    wire refSel = (timeSel == SEL_A) ? refTick[0] :
                  (timeSel == SEL_B) ? refTick[1] :
                  (timeSel == SEL_C) ? refTick[2] : 1'b0;

    // gate length in ms ticks
    wire [3:0] gateLen = (timeSel == SEL_A) ? 4'(GATE_A_MS) :
                         (timeSel == SEL_B) ? 4'(GATE_B_MS) : 4'(GATE_C_MS);
    wire gateOpenEnd = (timeSel == SEL_OPEN);
    wire msTick      = refTick[0];
    wire ifDone      = (state_ff == ST_IFON) && !gateOpenEnd && msTick
                       && (msCnt_ff + 4'h1 == gateLen);
    wire extDone     = (state_ff == ST_MEAS) && gateFall;

    // any change of mode or channel stops the running function
    wire abort = wrMode || wrChan;

    always_comb begin
        nxt_state = state_ff;
        nxt_msCnt = msCnt_ff;
        unique case (state_ff)
            ST_IDLE: ;
            ST_IFON: begin
                if (ifDone) begin
                    nxt_state = ST_IDLE;
                end else if (msTick) begin
                    nxt_msCnt = msCnt_ff + 4'h1;
                end
            end
            ST_ARM: begin
                if (gateRise) begin
                    nxt_state = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (gateFall) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (abort) begin
            nxt_state = ST_IDLE;
        end else if (startCmd) begin
            nxt_state = isExt ? ST_ARM : ST_IFON;
            nxt_msCnt = 4'h0;
        end
    end

    assign tbRestart = startCmd;

    // count source: at most one function feeds the counter
    assign cif.inc = ((state_ff == ST_IFON) && ifEdge)
                   || ((state_ff == ST_MEAS) && refSel);
    assign cif.clr = clearCmd;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            msCnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            msCnt_ff <= nxt_msCnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ifPinPrev_ff <= 1'b0;
            gatePrev_ff  <= 1'b0;
            halfPhase_ff <= 1'b0;
        end else begin
            ifPinPrev_ff <= ifPin;
            gatePrev_ff  <= gateLvl;
            if (startCmd) begin
                halfPhase_ff <= 1'b0;
            end else if (ifRise) begin
                halfPhase_ff <= !halfPhase_ff;
            end
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_ff    <= MODE_RST;
            chanSel_ff <= CHAN_RST;
            portDir_ff <= PORT_RST;
            portOut_ff <= PORT_RST;
            irqMask_ff <= IRQ_RST;
        end else begin
            if (wrMode) begin
                mode_ff <= wrData[3:0];
            end
            if (wrChan) begin
                chanSel_ff <= wrData[1:0];
            end
            if (wrPort) begin
                portDir_ff <= wrData[1:0];
                portOut_ff <= wrData[3:2];
            end
            if (wrMask) begin
                irqMask_ff <= wrData[IRQ_W-1:0];
            end
        end
    end

    // sticky events, set beats write-one-to-clear
    wire [IRQ_W-1:0] evt;
    assign evt[IRQ_IF_DONE]  = ifDone;
    assign evt[IRQ_EXT_DONE] = extDone;
    assign evt[IRQ_SAT]      = cif.satPulse;
    wire [IRQ_W-1:0] irqClr = wrIrqSt ? wrData[IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqSt_ff <= IRQ_RST;
        end else begin
            irqSt_ff <= (irqSt_ff & ~irqClr) | evt;
        end
    end

    assign irq = |(irqSt_ff & irqMask_ff);

    // gate pins as general-purpose I/O; direction bit set means output
    assign gateInputPinA_o  = portOut_ff[0];
    assign gateInputPinA_oe = portDir_ff[0];
    assign gateInputPinB_o  = portOut_ff[1];
    assign gateInputPinB_oe = portDir_ff[1];

    assign gateOpenFlag = (state_ff == ST_IFON);

    // read path; unmapped and write-only addresses read zero
    wire [3:0] pinLevels = {amIfInputPin, fmIfInputPin, gateInputPinB_i, gateInputPinA_i};
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        rdMux = '0;
        unique case (addr)
            ADDR_CHAN:     rdMux[1:0]       = chanSel_ff;
            ADDR_PORT:     rdMux[3:0]       = {portOut_ff, portDir_ff};
            ADDR_MODE:     rdMux[3:0]       = mode_ff;
            ADDR_GSTAT:    rdMux[GSTAT_OPEN_BIT] = gateOpenFlag;
            ADDR_IRQ_ST:   rdMux[IRQ_W-1:0] = irqSt_ff;
            ADDR_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_ff;
            ADDR_COUNT:    rdMux            = cif.value;
            ADDR_PINS:     rdMux[3:0]       = pinLevels;
            default:       rdMux            = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdData_ff <= '0;
        end else begin
            rdData_ff <= rdEn ? rdMux : '0;
        end
    end

    assign rdData = rdData_ff;
endmodule
`default_nettype wire

// [fcg_top_properties.sv]
// Purpose: port properties of fcg_top
// Assumes: mode register shadowed from register port writes
// Notes:   bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module fcg_top_properties import fcg_pkg::*; #(
    parameter int ClkKhz = CLK_KHZ
) (
    // clock, reset and register port
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic              wrEn,
    input wire logic              rdEn,
    input wire logic [DATA_W-1:0] rdData,
    // pins and status
    input wire logic              gateInputPinA_o,
    input wire logic              gateInputPinA_oe,
    input wire logic              gateInputPinB_o,
    input wire logic              gateInputPinB_oe,
    input wire logic              gateOpenFlag,
    input wire logic              irq
);
    wire logic        wrMode  = wrEn && addr == ADDR_MODE;
    wire logic        wrPort  = wrEn && addr == ADDR_PORT;
    wire logic        wrStart = wrEn && addr == ADDR_CTRL && wrData[CTRL_START_BIT];
    wire logic        abort   = wrMode || (wrEn && addr == ADDR_CHAN);
    wire logic [3:0]  pinOut  = {gateInputPinB_o, gateInputPinA_o, gateInputPinB_oe, gateInputPinA_oe};
    logic      [3:0]  mode_ff;
    logic      [19:0] openCnt_ff;
    wire logic [19:0] lenCyc  = 20'(ClkKhz) * 20'(mode_ff[1:0] == SEL_A ? GATE_A_MS :
                                mode_ff[1:0] == SEL_B ? GATE_B_MS : GATE_C_MS);
    // cycles the IF gate has stood open since the last start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_ff    <= MODE_RST;
            openCnt_ff <= 20'h00000;
        end else begin
            if (wrMode) mode_ff <= wrData[3:0];
            if (wrStart) openCnt_ff <= 20'h00000;
            else if (gateOpenFlag) openCnt_ff <= openCnt_ff + 20'h00001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rst_idle; $rose(rst_b) |-> !gateOpenFlag && !irq && pinOut == 4'h0; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
    property p_start_if; wrStart && mode_ff[3:2] != FUNC_EXT |=> gateOpenFlag; endproperty
    a_start_if: assert property (p_start_if) else $error("IF gate did not open");
    property p_ext_shut;
        $past(mode_ff[3:2]) == FUNC_EXT && mode_ff[3:2] == FUNC_EXT |-> !gateOpenFlag;
    endproperty
    a_ext_shut: assert property (p_ext_shut) else $error("IF gate open in gate mode");
    property p_gate_len;
        $fell(gateOpenFlag) && !$past(abort) && mode_ff[1:0] != SEL_OPEN
            |-> openCnt_ff + 20'h00002 >= lenCyc && openCnt_ff <= lenCyc + 20'h00002;
    endproperty
    a_gate_len: assert property (p_gate_len) else $error("IF gate length wrong");
    property p_open_hold;
        mode_ff == {FUNC_AM, SEL_OPEN} && gateOpenFlag && !abort |=> gateOpenFlag;
    endproperty
    a_open_hold: assert property (p_open_hold) else $error("open gate closed");
    property p_port_out; wrPort |=> pinOut == $past(wrData[3:0]); endproperty
    a_port_out: assert property (p_port_out) else $error("pin drive wrong");
    property p_port_hold; !wrPort |=> $stable(pinOut); endproperty
    a_port_hold: assert property (p_port_hold) else $error("pin drive moved");
    property p_mode_rb; rdEn && addr == ADDR_MODE |=> rdData == {12'h000, $past(mode_ff)}; endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
endmodule
`default_nettype wire

// [fcg_src_model.sv]
// Purpose: IF signal and gate pulse sources at the pins of fcg_top
// Assumes: a pulse starts on a one-cycle pulseGo
// Notes:   FM rises every 2 cycles, AM every 4; both stand low when stopped
`timescale 1ns/100ps
`default_nettype none
module fcg_src_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // control
    input  wire logic        ifRun,
    input  wire logic        pulseGo,
    input  wire logic [15:0] pulseLen,
    input  wire logic        pulseOnB,
    // pins
    output logic             fmPin,
    output logic             amPin,
    output logic             gateA,
    output logic             gateB
);
    logic [1:0]  phase_ff;
    logic [15:0] left_ff;
    always_ff @(posedge clk) begin
        phase_ff <= (rst_b && ifRun) ? phase_ff + 2'h1 : 2'h0;
        left_ff  <= !rst_b ? 16'h0000 : pulseGo ? pulseLen : left_ff - 16'(left_ff != 16'h0000);
    end
    assign fmPin = phase_ff[0];
    assign amPin = phase_ff[1];
    assign gateA = !pulseOnB && left_ff != 16'h0000;
    assign gateB = pulseOnB && left_ff != 16'h0000;
endmodule
`default_nettype wire

// [fcg_top_tb.sv]
// Purpose: self-checking bench for fcg_top
// Assumes: ClkKhz of 2000, so 1 ms is 2000 cycles
// Notes:   pins come from fcg_src_model unless the gate pin is an output
`timescale 1ns/100ps
`default_nettype none
module fcg_top_tb import fcg_pkg::*;;
    localparam int K = 2000;
    logic        clk, rst_b, wrEn, rdEn, ifRun, pulseGo, pulseOnB;
    logic [7:0]  addr;
    logic [15:0] wrData, pulseLen, rdData, rv;
    logic        fmPin, amPin, srcA, srcB, aO, aOe, bO, bOe, gateOpenFlag, irq;
    int          miscompares = 0;
    int          samplesChecked = 0;
    wire logic   pinA = aOe ? aO : srcA;
    wire logic   pinB = bOe ? bO : srcB;
    fcg_top #(.ClkKhz(K)) uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .fmIfInputPin(fmPin), .amIfInputPin(amPin),
        .gateInputPinA_i(pinA), .gateInputPinA_o(aO), .gateInputPinA_oe(aOe),
        .gateInputPinB_i(pinB), .gateInputPinB_o(bO), .gateInputPinB_oe(bOe),
        .gateOpenFlag(gateOpenFlag), .irq(irq));
    fcg_src_model src (.clk(clk), .rst_b(rst_b), .ifRun(ifRun), .pulseGo(pulseGo),
        .pulseLen(pulseLen), .pulseOnB(pulseOnB), .fmPin(fmPin), .amPin(amPin),
        .gateA(srcA), .gateB(srcB));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] lo, hi, g);
        samplesChecked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("unexpected %s: expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
        @(posedge clk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [15:0] lo, hi, input string n);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 rv = rdData;
        chk(n, lo, hi, rv);
        @(posedge clk);
    endtask
    task automatic waitFlag(input logic lvl, input int lim);
        int i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (gateOpenFlag !== lvl && i < lim);
        chk("gateOpenFlag", 16'(lvl), 16'(lvl), 16'(gateOpenFlag));
        if (gateOpenFlag !== lvl) test_done();
        @(posedge clk);
    endtask
    task automatic t_regs();
        logic [7:0] r [8] = '{ADDR_CHAN, ADDR_PORT, ADDR_MODE, ADDR_CTRL, ADDR_GSTAT,
                              ADDR_IRQ_ST, ADDR_IRQ_MASK, ADDR_COUNT};
        foreach (r[i]) rchk(r[i], 16'h0000, 16'h0000, $sformatf("reg %h", r[i]));
        wr(ADDR_MODE, 16'hFFFF);
        rchk(ADDR_MODE, 16'h000F, 16'h000F, "mode");
        wr(ADDR_PORT, 16'h000F);
        chk("pin drive", 16'h000F, 16'h000F, {12'h000, bO, aO, bOe, aOe});
        rchk(ADDR_PINS, 16'h0003, 16'h0003, "gate pins as outputs");
        wr(8'h30, 16'hFFFF);
        rchk(8'h30, 16'h0000, 16'h0000, "unmapped");
        wr(ADDR_PORT, 16'h0000);
        wr(ADDR_MODE, 16'h0000);
        $display("registers done");
    endtask
    task automatic t_if();
        int         ms [5] = '{1, 4, 8, 1, 1};
        int         dv [5] = '{4, 4, 4, 4, 2};
        logic [3:0] md [5] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hC};
        int         e;
        ifRun <= 1'b1;
        foreach (md[i]) begin
            e = ms[i] * K / dv[i];
            wr(ADDR_MODE, {12'h000, md[i]});
            wr(ADDR_CTRL, 16'h0003);
            rchk(ADDR_GSTAT, 16'h0001, 16'h0001, "gate status");
            waitFlag(1'b0, ms[i] * K + 50);
            rchk(ADDR_COUNT, 16'(e - 3), 16'(e + 3), "if count");
        end
        wr(ADDR_CTRL, 16'h0001);
        rchk(ADDR_COUNT, 16'h0000, 16'h0000, "cleared count");
        wr(ADDR_MODE, 16'h0007);
        wr(ADDR_CTRL, 16'h0003);
        repeat (300) @(negedge clk);
        chk("open gate", 16'h0001, 16'h0001, {15'h0000, gateOpenFlag});
        @(posedge clk);
        // unselected fm pin must stay readable while am is counted
        addr <= ADDR_PINS;
        rdEn <= 1'b1;
        @(negedge clk);
        rv = {12'h000, amPin, fmPin, pinB, pinA};
        @(posedge clk);
        rdEn <= 1'b0;
        #1 chk("pin levels", rv, rv, rdData);
        @(posedge clk);
        wr(ADDR_MODE, 16'h0000);
        waitFlag(1'b0, 4);
        ifRun <= 1'b0;
        $display("if counting done");
    endtask
    task automatic t_ext();
        logic [3:0] md [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1};
        logic [1:0] ch [7] = '{CHAN_PIN_A, CHAN_PIN_A, CHAN_PIN_A, CHAN_PIN_A,
                               CHAN_PIN_B, CHAN_PIN_B, CHAN_PIN_A};
        logic       pb [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        int         ln [7] = '{4000, 1000, 1000, 1000, 1000, 1000, 1000};
        int         rk [7] = '{REF_A_KHZ, REF_B_KHZ, REF_C_KHZ, 0, REF_B_KHZ, 0, 0};
        int         e;
        foreach (md[i]) begin
            e = rk[i] * ln[i] / K;
            wr(ADDR_CHAN, {14'h0000, ch[i]});
            wr(ADDR_PORT, {15'h0000, i == 6});
            wr(ADDR_MODE, {12'h000, md[i]});
            wr(ADDR_CTRL, 16'h0003);
            pulseOnB <= pb[i];
            pulseLen <= 16'(ln[i]);
            pulseGo <= 1'b1;
            @(posedge clk);
            pulseGo <= 1'b0;
            repeat (ln[i] + 20) @(posedge clk);
            rchk(ADDR_COUNT, 16'(e > 2 ? e - 2 : 0), 16'(e == 0 ? 0 : e + 2), "gate count");
        end
        wr(ADDR_PORT, 16'h0000);
        $display("gate counting done");
    endtask
    task automatic t_irq();
        wr(ADDR_IRQ_MASK, 16'h0000);
        chk("irq masked", 16'h0000, 16'h0000, {15'h0000, irq});
        rchk(ADDR_IRQ_ST, 16'h0003, 16'h0003, "events");
        wr(ADDR_IRQ_MASK, 16'h0002);
        chk("irq raised", 16'h0001, 16'h0001, {15'h0000, irq});
        wr(ADDR_IRQ_ST, 16'h0002);
        chk("irq cleared", 16'h0000, 16'h0000, {15'h0000, irq});
        rchk(ADDR_IRQ_ST, 16'h0001, 16'h0001, "events left");
        $display("interrupts done");
    endtask
    initial begin
        {rst_b, wrEn, rdEn, ifRun, pulseGo, pulseOnB} = 6'h00;
        addr = 8'h00;
        wrData = 16'h0000;
        pulseLen = 16'h0000;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_if();
        t_ext();
        t_irq();
        test_done();
    end
endmodule
bind fcg_top fcg_top_properties #(.ClkKhz(ClkKhz)) props (.clk(clk), .rst_b(rst_b),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .gateInputPinA_o(gateInputPinA_o), .gateInputPinA_oe(gateInputPinA_oe),
    .gateInputPinB_o(gateInputPinB_o), .gateInputPinB_oe(gateInputPinB_oe),
    .gateOpenFlag(gateOpenFlag), .irq(irq));
`default_nettype wire
